// ===== design/vse_regs.sv
// wishbone register bank for video select and enhancement control
//
// Implementation choice: the Wishbone interface to the registers.
`default_nettype none
module vse_regs (
	input wire logic clk_i, // 100 MHz clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic cyc_i, // wishbone cycle
	input wire logic stb_i, // wishbone strobe
	input wire logic we_i, // wishbone write enable
	input wire logic [vse_pkg::ADR_W-1:0] adr_i, // byte address
	input wire logic [3:0] sel_i, // byte selects
	input wire logic [31:0] dat_i, // write data
	output logic [31:0] dat_o, // read data
	output logic ack_o, // wishbone acknowledge
	output vse_pkg::vse_cfg_s cfg_o, // decoded configuration
	output logic llc_rate_x4_o, // line-locked clock at 4x subcarrier
	output logic peaking_boost_o, // peaking gain above unity
	output logic peaking_cut_o, // peaking gain below unity
	output logic [5:0] coring_thr_o, // coring threshold over black
	output logic reacquire_start_o // one-cycle reacquire request
);
	logic ack_r;
	logic [31:0] dat_r;
	logic reacq_r;
	logic [7:0] reacq_cnt_r;
	logic [5:0] thr_r;
	logic [5:0] thr_nxt;
	logic [7:0] in_q;
	logic [7:0] vs_q;
	logic [7:0] en_q;

	wire [5:0] idx = adr_i[7:2];
	wire req = cyc_i & stb_i & ~ack_r;
	wire wr = req & we_i & sel_i[0];
	wire hit_in = idx == vse_pkg::IDX_INPUT_CTRL;
	wire hit_vs = idx == vse_pkg::IDX_VIDEO_SEL;
	wire hit_en = idx == vse_pkg::IDX_ENHANCE;
	wire hit_st = idx == vse_pkg::IDX_STATUS;
	wire wr_in = wr & hit_in;
	wire wr_vs = wr & hit_vs;
	wire wr_en = wr & hit_en;
	wire [7:0] wdat = dat_i[7:0];
	wire [3:0] new_input_select_field = wdat[vse_pkg::POS_INPUT_SELECT_FIELD+:4];
	wire input_select_field_changed = wr_in & (new_input_select_field != cfg_o.input_select_field);
	// reacquire only while auto reacquire control is clear
	wire reacq_go = input_select_field_changed & ~cfg_o.auto_reacquire_control;

	wire [7:0] rd_byte;
	assign rd_byte = hit_in ? in_q :
		hit_vs ? vs_q :
		hit_en ? en_q :
		hit_st ? reacq_cnt_r : 8'h00;

	vse_cfg_reg #(
		.RST_VAL(vse_pkg::RST_INPUT_CTRL),
		.MASK(vse_pkg::MASK_INPUT_CTRL)
	) u_input_ctrl (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(wr_in),
		.d_i(wdat),
		.q_o(in_q)
	);

	vse_cfg_reg #(
		.RST_VAL(vse_pkg::RST_VIDEO_SEL),
		.MASK(vse_pkg::MASK_VIDEO_SEL)
	) u_video_sel (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(wr_vs),
		.d_i(wdat),
		.q_o(vs_q)
	);

	vse_cfg_reg #(
		.RST_VAL(vse_pkg::RST_ENHANCE),
		.MASK(vse_pkg::MASK_ENHANCE)
	) u_enhance (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(wr_en),
		.d_i(wdat),
		.q_o(en_q)
	);

	// field decode of the stored registers
	assign cfg_o.source_quality_class =
		vse_pkg::vse_quality_e'(vs_q[vse_pkg::POS_QUALITY+:2]);
	assign cfg_o.square_pixel_enable = vs_q[vse_pkg::POS_SQUARE];
	assign cfg_o.differential_input_enable =
		vs_q[vse_pkg::POS_DIFF];
	assign cfg_o.subcarrier_x4_resample = vs_q[vse_pkg::POS_X4];
	assign cfg_o.betacam_enable = vs_q[vse_pkg::POS_BETACAM];
	assign cfg_o.auto_reacquire_control = vs_q[vse_pkg::POS_AUTO_REACQ];
	assign cfg_o.luma_peaking_gain = en_q[vse_pkg::POS_PEAK+:3];
	assign cfg_o.luma_coring_level = en_q[vse_pkg::POS_CORING+:2];
	assign cfg_o.input_select_field = in_q[vse_pkg::POS_INPUT_SELECT_FIELD+:4];
	assign cfg_o.input_standard = in_q[vse_pkg::POS_STANDARD+:4];

	// the output clock follows the resampling rate
	assign llc_rate_x4_o = cfg_o.subcarrier_x4_resample;
	// lower codes boost, higher codes attenuate
	assign peaking_boost_o =
		cfg_o.luma_peaking_gain < vse_pkg::PEAK_UNITY;
	assign peaking_cut_o =
		cfg_o.luma_peaking_gain > vse_pkg::PEAK_UNITY;

	always_comb begin
		case (cfg_o.luma_coring_level)
			2'h1: thr_nxt = vse_pkg::CORE_THR_1;
			2'h2: thr_nxt = vse_pkg::CORE_THR_2;
			2'h3: thr_nxt = vse_pkg::CORE_THR_3;
			default: thr_nxt = 6'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req;
			dat_r <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reacq_r <= 1'b0;
			reacq_cnt_r <= 8'h00;
			thr_r <= 6'h00;
		end else begin
			reacq_r <= reacq_go;
			reacq_cnt_r <= reacq_cnt_r + {7'h00, reacq_go};
			thr_r <= thr_nxt;
		end
	end

	assign ack_o = ack_r;
	assign dat_o = dat_r;
	assign reacquire_start_o = reacq_r;
	assign coring_thr_o = thr_r;

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack held two cycles");
	a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	// read data and unmapped reads
	a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |-> dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && !hit_in && !hit_vs && !hit_en && !hit_st
		|=> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	// registers keep their value between writes
	a_vsel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_vs |=> $stable(vs_q))
		else $error("video select changed without write");
	a_enh_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_en |=> $stable(en_q))
		else $error("enhancement changed without write");
	a_inctl_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_in |=> $stable(in_q))
		else $error("input control changed without write");
	a_quality_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_vs |=> cfg_o.source_quality_class == $past(dat_i[1:0]))
		else $error("quality class not stored");
	a_square_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_vs |=> cfg_o.square_pixel_enable == $past(dat_i[2]))
		else $error("square pixel bit wrong");
	a_diff_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_vs |=> cfg_o.differential_input_enable == $past(dat_i[3]))
		else $error("differential bit wrong");
	a_x4_clock: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_vs |=> llc_rate_x4_o == $past(dat_i[4]))
		else $error("clock rate not following resample");
	a_reacq_pulse: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_in && dat_i[3:0] != cfg_o.input_select_field
		|=> reacquire_start_o == !$past(cfg_o.auto_reacquire_control))
		else $error("reacquire decision wrong");
	a_reacq_cause: assert property (
		@(posedge clk_i) disable iff (rst_i)
		reacquire_start_o |-> $past(wr_in) ##0 !$past(vs_q[7]))
		else $error("reacquire without cause");
	a_reacq_same: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_in && dat_i[3:0] == cfg_o.input_select_field
		|=> !reacquire_start_o)
		else $error("reacquire on unchanged select");
	a_reacq_count: assert property (
		@(posedge clk_i) disable iff (rst_i)
		reacquire_start_o |-> reacq_cnt_r == $past(reacq_cnt_r) + 8'h01)
		else $error("reacquire count not advanced");
	a_peak_unity: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_en && dat_i[2:0] == 3'h4 |=> !peaking_boost_o && !peaking_cut_o)
		else $error("unity gain flagged");
	a_peak_boost: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_en && dat_i[2:0] < 3'h4 |=> peaking_boost_o && !peaking_cut_o)
		else $error("boost code not flagged");
	a_peak_cut: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_en && dat_i[2:0] > 3'h4 |=> peaking_cut_o && !peaking_boost_o)
		else $error("cut code not flagged");
	a_coring_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_en && dat_i[4:3] == 2'h0 |=> ##1 coring_thr_o == 6'h00)
		else $error("coring not off");
	a_coring_thr: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_en && dat_i[4:3] == 2'h1 |=> ##1 coring_thr_o == 6'h08)
		else $error("coring threshold wrong");
	a_coring_mid: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_en && dat_i[4:3] == 2'h2 |=> ##1 coring_thr_o == 6'h10)
		else $error("middle coring threshold wrong");
	a_coring_top: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_en && dat_i[4:3] == 2'h3 |=> ##1 coring_thr_o == 6'h20)
		else $error("top coring threshold wrong");
endmodule : vse_regs
`default_nettype wire

// ===== inc/vse_pkg.sv
// shared constants and types for the video select/enhance register bank
`default_nettype none
package vse_pkg;
	localparam int ADR_W = 8;
	// register indexes; byte address is four times the index
	localparam logic [5:0] IDX_INPUT_CTRL = 6'h00;
	localparam logic [5:0] IDX_VIDEO_SEL = 6'h01;
	localparam logic [5:0] IDX_ENHANCE = 6'h02;
	localparam logic [5:0] IDX_STATUS = 6'h3f;
	// reset values
	localparam logic [7:0] RST_INPUT_CTRL = 8'h00;
	localparam logic [7:0] RST_VIDEO_SEL = 8'h00;
	localparam logic [7:0] RST_ENHANCE = 8'h04;
	// writable bit masks; reserved bits read as zero
	localparam logic [7:0] MASK_INPUT_CTRL = 8'hff;
	localparam logic [7:0] MASK_VIDEO_SEL = 8'hbf;
	localparam logic [7:0] MASK_ENHANCE = 8'h1f;
	// field positions
	localparam int POS_QUALITY = 0;
	localparam int POS_SQUARE = 2;
	localparam int POS_DIFF = 3;
	localparam int POS_X4 = 4;
	localparam int POS_BETACAM = 5;
	localparam int POS_AUTO_REACQ = 7;
	localparam int POS_PEAK = 0;
	localparam int POS_CORING = 3;
	localparam int POS_INPUT_SELECT_FIELD = 0;
	localparam int POS_STANDARD = 4;
	localparam logic [2:0] PEAK_UNITY = 3'h4;
	// coring thresholds above black level
	localparam logic [5:0] CORE_THR_1 = 6'h08;
	localparam logic [5:0] CORE_THR_2 = 6'h10;
	localparam logic [5:0] CORE_THR_3 = 6'h20;

	typedef enum logic [1:0] {
		VSE_QUAL_BROADCAST,
		VSE_QUAL_TV,
		VSE_QUAL_VCR,
		VSE_QUAL_SURVEIL
	} vse_quality_e;

	typedef struct packed {
		vse_quality_e source_quality_class;
		logic square_pixel_enable;
		logic differential_input_enable;
		logic subcarrier_x4_resample;
		logic betacam_enable;
		logic auto_reacquire_control;
		logic [2:0] luma_peaking_gain;
		logic [1:0] luma_coring_level;
		logic [3:0] input_select_field;
		logic [3:0] input_standard;
	} vse_cfg_s;
endpackage : vse_pkg
`default_nettype wire

// ===== design/vse_cfg_reg.sv
// one masked 8-bit configuration register
`default_nettype none
module vse_cfg_reg #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] MASK = 8'hff
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic we_i, // write strobe
	input wire logic [7:0] d_i, // write data
	output logic [7:0] q_o // stored value
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_o <= RST_VAL & MASK;
		end else if (we_i) begin
			q_o <= d_i & MASK;
		end
	end

	a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(q_o & ~MASK) == 8'h00) else $error("reserved bit set");
endmodule : vse_cfg_reg
`default_nettype wire

// ===== testbench/vse_host_model.sv
// wishbone host model that programs the register bank
`default_nettype none
module vse_host_model #(
	parameter logic [3:0] NTSC_STD = 4'h0 // input standard code for ntsc
) (
	input wire logic clk_i, // system clock
	input wire logic ack_i, // acknowledge
	input wire logic [31:0] dat_i, // read data
	output logic cyc_o, // cycle
	output logic stb_o, // strobe
	output logic we_o, // write enable
	output logic [7:0] adr_o, // byte address
	output logic [3:0] sel_o, // byte selects
	output logic [31:0] dat_o // write data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] std_r = NTSC_STD;
	initial begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	end
	// one classic cycle; reserved bits are written as zero at addresses 8'h04 and 8'h08, and bit 4 at 8'h04 too while the standard is not ntsc
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [7:0] d, output logic [31:0] q);
		logic [7:0] m;
		m = d;
		if (a == 8'h04) m = d & 8'hbf;
		if (a == 8'h04 && std_r != NTSC_STD) m[4] = 1'b0;
		if (a == 8'h08) m = d & 8'h1f;
		if (w && a == 8'h00) std_r = d[7:4];
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'h1;
		dat_o <= {24'h0, m};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
	endtask : xfer
endmodule : vse_host_model
`default_nettype wire

// ===== testbench/video_select_enhance_regs_test.sv
// self-checking bench for the video select/enhance register bank
`default_nettype none
module video_select_enhance_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack, x4, boost, cut, reacq;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [5:0] thr;
	vse_pkg::vse_cfg_s cfg;
	int error_cnt = 0;
	int checks_done = 0;
	int pulses = 0;
	int p;
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (reacq === 1'b1) pulses++;
	vse_host_model u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat));
	vse_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .cfg_o(cfg), .llc_rate_x4_o(x4),
		.peaking_boost_o(boost), .peaking_cut_o(cut), .coring_thr_o(thr),
		.reacquire_start_o(reacq));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, d, q);
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		u_host.xfer(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask : rd
	task close_out;
		$display("errors=%0d checks=%0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	initial begin
		repeat (5000) @(posedge clk_i);
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h4);
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, 8'(i));
			chk(32'(cfg.source_quality_class), i);
		end
		for (int b = 2; b < 6; b++) begin
			wr(8'h04, 8'(1 << b));
			chk({cfg.betacam_enable, cfg.subcarrier_x4_resample, x4,
				cfg.differential_input_enable, cfg.square_pixel_enable},
				{b == 5, {2{b == 4}}, b == 3, b == 2});
			rd(8'h04, 32'(1 << b));
		end
		for (int i = 0; i < 8; i++) begin
			wr(8'h08, 8'(i));
			chk({boost, cut, cfg.luma_peaking_gain},
				{i < 4, i > 4, 3'(i)});
		end
		for (int c = 0; c < 4; c++) begin
			wr(8'h08, 8'((c << 3) | 4));
			chk({cfg.luma_coring_level, thr},
				{2'(c), 6'(c ? 4 << c : 0)});
		end
		wr(8'h04, 8'h00);
		p = pulses;
		wr(8'h00, 8'h01);
		chk(pulses, p + 1);
		chk(32'(cfg.input_select_field), 32'h1);
		wr(8'h00, 8'h01);
		wr(8'h04, 8'h80);
		chk(32'(cfg.auto_reacquire_control), 32'h1);
		wr(8'h00, 8'h02);
		chk(pulses, p + 1);
		wr(8'h00, 8'h12);
		chk(32'(cfg.input_standard), 32'h1);
		wr(8'h04, 8'h90);
		chk(32'(x4), 32'h0);
		rd(8'h04, 32'h80);
		rd(8'hfc, 32'h1);
		wr(8'h40, 8'hff);
		rd(8'h40, 32'h0);
		close_out();
	end
endmodule : video_select_enhance_regs_test
`default_nettype wire
